// File: inc/sce_map.svh
// Purpose: Register map, field positions and reset values of the serial
//          port control and event block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Control, enable, aux and status registers hold 16 bits in the low half; upper bits read zero. TX and RX data are 32-bit words.
// Functional notes
// - With module_on clear the unit is held reset, stops and gives no event.
// - With idle_halt set the unit freezes while the processor idles.
// - With serial_out_disable set the serial_out_pin driver is released.
// - Without audio, word length codes 1x, 01, 00 give 32, 16 and 8 bits.
// - As master, data is sampled at the end of the bit if sample_phase is 1.
// - As slave, data is always sampled in the middle of the bit.
// - In DSP/PCM format the left_right_clock follows frame_sync_width.
// - busy_event_enable gates transfer_active_flag onto the event.
// - rx_full_event_enable gates rx_full_flag onto the event.
// - tx_full_event_enable gates tx_full_flag onto the event.
`ifndef SCE_MAP_SVH
`define SCE_MAP_SVH

// ==========================================================
// Offsets
`define SCE_OFF_CTRL 8'h00
`define SCE_OFF_EVEN 8'h04
`define SCE_OFF_AUX 8'h08
`define SCE_OFF_STAT 8'h0C
`define SCE_OFF_TX 8'h10
`define SCE_OFF_RX 8'h14

// ==========================================================
// serial_control_low fields
`define SCE_B_ON 15
`define SCE_B_IDLE 13
`define SCE_B_SDOD 12
`define SCE_B_WUP 11
`define SCE_B_WLO 10
`define SCE_B_PHASE 9
`define SCE_B_CKE 8
`define SCE_B_CKP 6
`define SCE_B_MST 5

// ==========================================================
// Event enable and status fields share positions
`define SCE_B_FRM 12
`define SCE_B_BUSY 11
`define SCE_B_UDR 8
`define SCE_B_SHE 7
`define SCE_B_OVF 6
`define SCE_B_RXE 5
`define SCE_B_TXE 3
`define SCE_B_TXF 1
`define SCE_B_RXF 0

// ==========================================================
// Audio and clock setup fields
`define SCE_B_AUD 0
`define SCE_B_DSP 1
`define SCE_B_FSW 2
`define SCE_B_DIV 8

// ==========================================================
// Masks and reset values
`define SCE_MASK_CTRL 16'hBFFF
`define SCE_MASK_EVEN 16'h19EB
`define SCE_MASK_AUX 16'hFF07
`define SCE_MASK_W1C 16'h1140
`define SCE_RST 16'h0000

`endif

// File: inc/sce_pkg.sv
// Purpose: Types shared by the serial port control block.
// Assumes: Nothing.
// Notes:   Constants live in sce_map.svh.
package sce_pkg;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_STORE = 3'b100
   } sce_state_t;
endpackage

// File: inc/sce_fifo_if.sv
// Purpose: Word stream between the block and its FIFOs.
// Assumes: Single clock.
// Notes:   Valid and ready on both sides.
`timescale 1ns/1ps
interface sce_fifo_if #(parameter int W = 32);
   logic [W-1:0] wdata;
   logic wvalid;
   logic wready;
   logic [W-1:0] rdata;
   logic rvalid;
   logic rready;
   modport fill (output wdata, output wvalid, input wready);
   modport drain (input rdata, input rvalid, output rready);
   modport fifo (input wdata, input wvalid, output wready,
                 output rdata, output rvalid, input rready);
endinterface

// File: src/sce_fifo.sv
// Purpose: Small synchronous FIFO with registered read data.
// Assumes: DEPTH is a power of two, at least 2.
// Notes:   Flush empties it in one cycle.
`timescale 1ns/1ps
module sce_fifo #(parameter int WIDTH = 32, parameter int DEPTH = 8)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flush,
   sce_fifo_if.fifo q
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(q.wdata) != WIDTH)
   begin : g_bad
      $error("sce_fifo: bad WIDTH or DEPTH");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;

   wire push = q.wvalid & q.wready;
   wire pop = q.rvalid & q.rready;
   wire [AW-1:0] rptr_n = rptr + AW'(pop);
   wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   assign q.wready = count != (AW+1)'(DEPTH);
   assign q.rvalid = count != '0;

   always_ff @(posedge pclk)
   begin
      if (push)
         mem[wptr] <= q.wdata;
   end

   // Head word is kept in a register, including a write to an empty FIFO
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         q.rdata <= '0;
      end
      else if (flush)
      begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end
      else
      begin
         wptr <= wptr + AW'(push);
         rptr <= rptr_n;
         count <= next_count;
         q.rdata <= (push && wptr == rptr_n) ? q.wdata : mem[rptr_n];
      end
   end
endmodule

// File: src/sce_spi_ctrl.sv
// Purpose: Serial port with control word, event enables and data FIFOs.
// Assumes: Link pins arrive asynchronously to pclk.
// Notes:   Master clock is pclk divided; slave follows sampled sck_in.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "sce_map.svh"
module sce_spi_ctrl #(parameter int DEPTH = 8)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_idle,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic sdi,
   output logic serial_out_pin,
   output logic serial_out_oe,
   input wire logic slave_sel_n,
   output logic left_right_clock,
   output logic left_right_oe,
   output logic event_out
);
   if (DEPTH < 2)
   begin : g_bad
      $error("sce_spi_ctrl: DEPTH too small");
   end

   // ==========================================================
   // Width decoding
   // Data bits per word
   function automatic logic [5:0] word_bits(input logic up,
      input logic lo, input logic aud);
      if (!aud)
         word_bits = up ? 6'd32 : (lo ? 6'd16 : 6'd8);
      else if (up)
         word_bits = lo ? 6'd24 : 6'd32;
      else
         word_bits = 6'd16;
   endfunction

   // Bits shifted per channel
   function automatic logic [5:0] chan_bits(input logic up,
      input logic lo, input logic aud);
      if (aud && (up || lo))
         chan_bits = 6'd32;
      else
         chan_bits = word_bits(up, lo, aud);
   endfunction

   // ==========================================================
   // Registers and state
   logic [15:0] serial_control_low;
   logic [15:0] serial_event_enable_low;
   logic [15:0] serial_aux;
   logic ovf_flag;
   logic udr_flag;
   logic frm_flag;
   sce_pkg::sce_state_t state;
   logic [5:0] bit_cnt;
   logic half;
   logic pend;
   logic chan_sel;
   logic [7:0] div_cnt;
   logic [31:0] tx_sh;
   logic [31:0] rx_sh;
   logic sck_s1, sck_s2, sck_s3;
   logic sdi_s1, sdi_s2;
   logic ss_s1, ss_s2;

   sce_fifo_if #(.W(32)) txq ();
   sce_fifo_if #(.W(32)) rxq ();

   // ==========================================================
   // Configuration
   wire module_on = serial_control_low[`SCE_B_ON];
   wire master_mode = serial_control_low[`SCE_B_MST];
   wire audio_protocol_enable = serial_aux[`SCE_B_AUD];
   wire dsp_mode = serial_aux[`SCE_B_DSP];
   wire frame_sync_width = serial_aux[`SCE_B_FSW];
   wire clk_idle_high = serial_control_low[`SCE_B_CKP];
   wire cke_eff = serial_control_low[`SCE_B_CKE]
      & ~audio_protocol_enable;
   wire phase_end = master_mode
      & serial_control_low[`SCE_B_PHASE];
   wire halt = serial_control_low[`SCE_B_IDLE] & cpu_idle;
   wire run = module_on & ~halt;
   wire [5:0] wb = word_bits(serial_control_low[`SCE_B_WUP],
      serial_control_low[`SCE_B_WLO], audio_protocol_enable);
   wire [5:0] cb = chan_bits(serial_control_low[`SCE_B_WUP],
      serial_control_low[`SCE_B_WLO], audio_protocol_enable);
   wire [7:0] half_div = (serial_aux[15:8] == 8'h00) ? 8'h01
      : serial_aux[15:8];

   // ==========================================================
   // Shift engine control
   wire in_idle = state == sce_pkg::ST_IDLE;
   wire in_shift = state == sce_pkg::ST_SHIFT;
   wire in_store = state == sce_pkg::ST_STORE;
   wire tick = in_shift & run & master_mode & (div_cnt == 8'h00);
   wire m_samp = tick & (half ? phase_end : ~phase_end);
   wire m_end = tick & half;
   wire rise = sck_s2 & ~sck_s3;
   wire fall = ~sck_s2 & sck_s3;
   wire lead = clk_idle_high ? fall : rise;
   wire trail = clk_idle_high ? rise : fall;
   wire s_act = in_shift & run & ~master_mode;
   wire s_samp = s_act & (cke_eff ? trail : lead);
   wire s_move = s_act & (cke_eff ? lead : trail) & pend;
   wire samp = master_mode ? m_samp : s_samp;
   wire move = master_mode ? m_end : s_move;
   wire dec = master_mode ? m_end : s_samp;
   wire s_abort = s_act & ss_s2;
   wire start = in_idle & run
      & (master_mode ? txq.rvalid : ~ss_s2);
   wire [31:0] tx_load = txq.rvalid
      ? (txq.rdata << (6'd32 - wb)) : 32'h0000_0000;
   wire [31:0] rx_word = rx_sh >> (cb - wb);

   assign txq.rready = start;
   assign rxq.wvalid = in_store;
   assign rxq.wdata = rx_word;

   wire underrun_set = start & ~master_mode & ~txq.rvalid;
   wire overflow_set = in_store & ~rxq.wready;

   // ==========================================================
   // Status and event
   wire transfer_active_flag = ~in_idle;
   wire rx_full_flag = ~rxq.wready;
   wire tx_full_flag = ~txq.wready;
   wire [15:0] stat = {3'b000, frm_flag, transfer_active_flag,
      2'b00, udr_flag, in_idle, ovf_flag, ~rxq.rvalid, 1'b0,
      ~txq.rvalid, 1'b0, tx_full_flag, rx_full_flag};
   wire ev_any = |(stat & serial_event_enable_low);

   // ==========================================================
   // APB decode
   wire hit_ctrl = paddr == `SCE_OFF_CTRL;
   wire hit_even = paddr == `SCE_OFF_EVEN;
   wire hit_aux = paddr == `SCE_OFF_AUX;
   wire hit_stat = paddr == `SCE_OFF_STAT;
   wire hit_tx = paddr == `SCE_OFF_TX;
   wire hit_rx = paddr == `SCE_OFF_RX;
   wire mapped = hit_ctrl | hit_even | hit_aux | hit_stat
      | hit_tx | hit_rx;
   wire acc = psel & penable & ~pready;
   wire tx_wait = hit_tx & pwrite & ~txq.wready & module_on;
   wire done = acc & ~tx_wait;
   wire wr = done & pwrite;
   wire [15:0] w16 = pwdata[15:0];
   wire [15:0] clr = (wr & hit_stat) ? (w16 & `SCE_MASK_W1C)
      : `SCE_RST;
   wire [31:0] rd_mux =
      hit_ctrl ? {16'h0000, serial_control_low} :
      hit_even ? {16'h0000, serial_event_enable_low} :
      hit_aux ? {16'h0000, serial_aux} :
      hit_stat ? {16'h0000, stat} :
      (hit_rx & rxq.rvalid) ? rxq.rdata : 32'h0000_0000;

   assign txq.wvalid = wr & hit_tx & module_on;
   assign txq.wdata = pwdata;
   assign rxq.rready = done & ~pwrite & hit_rx;

   sce_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_txf
   (
      .pclk(pclk),
      .presetn(presetn),
      .flush(~module_on),
      .q(txq)
   );

   sce_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_rxf
   (
      .pclk(pclk),
      .presetn(presetn),
      .flush(~module_on),
      .q(rxq)
   );

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {sck_s1, sck_s2, sck_s3} <= 3'h0;
         {sdi_s1, sdi_s2} <= 2'h0;
         {ss_s1, ss_s2} <= 2'h3;
      end
      else
      begin
         {sck_s1, sck_s2, sck_s3} <= {sck_in, sck_s1, sck_s2};
         {sdi_s1, sdi_s2} <= {sdi, sdi_s1};
         {ss_s1, ss_s2} <= {slave_sel_n, ss_s1};
      end
   end

   // ==========================================================
   // APB registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         serial_control_low <= `SCE_RST;
         serial_event_enable_low <= `SCE_RST;
         serial_aux <= `SCE_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= done;
         pslverr <= done & ~mapped;
         prdata <= (done & ~pwrite) ? rd_mux : 32'h0000_0000;
         if (wr & hit_ctrl)
            serial_control_low <= w16 & `SCE_MASK_CTRL;
         if (wr & hit_even)
            serial_event_enable_low <= w16 & `SCE_MASK_EVEN;
         if (wr & hit_aux)
            serial_aux <= w16 & `SCE_MASK_AUX;
      end
   end

   // Sticky error flags; a new error wins over a clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ovf_flag <= 1'b0;
         udr_flag <= 1'b0;
         frm_flag <= 1'b0;
      end
      else if (!module_on)
      begin
         ovf_flag <= 1'b0;
         udr_flag <= 1'b0;
         frm_flag <= 1'b0;
      end
      else
      begin
         ovf_flag <= overflow_set | (ovf_flag & ~clr[`SCE_B_OVF]);
         udr_flag <= underrun_set | (udr_flag & ~clr[`SCE_B_UDR]);
         frm_flag <= s_abort | (frm_flag & ~clr[`SCE_B_FRM]);
      end
   end

   // ==========================================================
   // Shift engine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= sce_pkg::ST_IDLE;
         bit_cnt <= 6'd0;
         half <= 1'b0;
         pend <= 1'b0;
         chan_sel <= 1'b0;
         div_cnt <= 8'h00;
         tx_sh <= 32'h0000_0000;
         rx_sh <= 32'h0000_0000;
      end
      else if (!module_on)
      begin
         state <= sce_pkg::ST_IDLE;
         half <= 1'b0;
         pend <= 1'b0;
         chan_sel <= 1'b0;
      end
      else
      begin
         unique case (state)
            sce_pkg::ST_IDLE:
            begin
               if (start)
               begin
                  state <= sce_pkg::ST_SHIFT;
                  tx_sh <= tx_load;
                  rx_sh <= 32'h0000_0000;
                  bit_cnt <= cb;
                  half <= 1'b0;
                  pend <= 1'b0;
                  div_cnt <= half_div - 8'h01;
               end
            end
            sce_pkg::ST_SHIFT:
            begin
               if (tick)
                  div_cnt <= half_div - 8'h01;
               else if (run && master_mode)
                  div_cnt <= div_cnt - 8'h01;
               if (tick)
                  half <= ~half;
               if (samp)
                  rx_sh <= {rx_sh[30:0], sdi_s2};
               if (move)
                  tx_sh <= {tx_sh[30:0], 1'b0};
               if (s_samp)
                  pend <= 1'b1;
               else if (s_move)
                  pend <= 1'b0;
               if (dec)
                  bit_cnt <= bit_cnt - 6'd1;
               if (s_abort)
                  state <= sce_pkg::ST_IDLE;
               else if (dec && bit_cnt == 6'd1)
                  state <= sce_pkg::ST_STORE;
            end
            sce_pkg::ST_STORE:
            begin
               state <= sce_pkg::ST_IDLE;
               if (audio_protocol_enable)
                  chan_sel <= ~chan_sel;
            end
         endcase
      end
   end

   // ==========================================================
   // Pin drivers and event output
   wire sck_active = in_shift & master_mode & (cke_eff ? ~half : half);
   wire first_bit = in_shift & (bit_cnt == cb);
   wire lr_pulse = ~chan_sel & (frame_sync_width | first_bit);
   wire next_left_right_clock = dsp_mode ? lr_pulse : chan_sel;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
         serial_out_pin <= 1'b0;
         serial_out_oe <= 1'b0;
         left_right_clock <= 1'b0;
         left_right_oe <= 1'b0;
         event_out <= 1'b0;
      end
      else
      begin
         sck_out <= clk_idle_high ^ sck_active;
         sck_oe <= module_on & master_mode;
         serial_out_pin <= tx_sh[31];
         serial_out_oe <= module_on
            & ~serial_control_low[`SCE_B_SDOD];
         left_right_clock <= module_on & master_mode
            & audio_protocol_enable & next_left_right_clock;
         left_right_oe <= module_on & master_mode & audio_protocol_enable;
         event_out <= module_on & ev_any;
      end
   end
endmodule

// File: dv/sce_spi_ctrl_monitor.sv
// Purpose: Port checks of the serial control block.
// Assumes: Shadows follow completed APB writes.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module sce_spi_ctrl_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic serial_out_oe,
   input wire logic left_right_oe,
   input wire logic event_out
);
   logic [15:0] ctrl;
   logic [15:0] even;
   wire acc = psel && penable && pready;
   wire rd_ok = acc && !pwrite && !pslverr;
   // ==========================================================
   // Shadow copies of the two words
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= 16'h0000;
         even <= 16'h0000;
      end
      else if (acc && pwrite && paddr == 8'h00)
         ctrl <= pwdata[15:0] & 16'hBFFF;
      else if (acc && pwrite && paddr == 8'h04)
         even <= pwdata[15:0] & 16'h19EB;
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_plain_answer: assert property (psel && penable && !pready &&
      !(pwrite && paddr == 8'h10) |=> pready)
      else $error("no answer after one wait state");
   a_err_unmapped: assert property (acc |-> pslverr == !(paddr inside
      {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
      else $error("pslverr does not match address");
   a_off_quiet: assert property (!ctrl[15] [*2] |-> !event_out)
      else $error("event while module off");
   a_off_pins: assert property (!ctrl[15] [*2] |-> !sck_oe && !left_right_oe)
      else $error("pin driven while module off");
   a_sck_idle: assert property ($stable(ctrl) && !sck_oe |->
      sck_out == ctrl[6])
      else $error("serial clock not at idle level");
   a_sdo_release: assert property ($stable(ctrl) |->
      serial_out_oe == (ctrl[15] && !ctrl[12]))
      else $error("serial output enable wrong");
   a_ctrl_read: assert property (rd_ok && paddr == 8'h00 |->
      prdata == {16'h0000, ctrl})
      else $error("control readback wrong");
   a_even_read: assert property (rd_ok && paddr == 8'h04 |->
      prdata == {16'h0000, even})
      else $error("enable readback wrong");
   a_none_quiet: assert property (even == 16'h0000 [*2] |-> !event_out)
      else $error("event with all enables clear");
   c_error: cover property (acc && pslverr);
   c_event: cover property ($rose(event_out));
   c_sdo: cover property ($rose(serial_out_oe));
endmodule

// File: dv/sce_link_model.sv
// Purpose: External link master on the slave pins.
// Assumes: Eight-bit words, MSB first, clock idle low.
// Notes: Clock stands still between frames.
`timescale 1ns/1ps
module sce_link_model
(
   input wire logic go,
   input wire logic [7:0] tx_byte,
   input wire logic serial_out_pin,
   output logic sck_in,
   output logic slave_sel_n,
   output logic sdi,
   output logic [7:0] rx_byte,
   output logic done
);
   initial
   begin
      sck_in = 1'b0;
      slave_sel_n = 1'b1;
      sdi = 1'b0;
      rx_byte = 8'h00;
      done = 1'b1;
   end
   // ==========================================================
   // One frame per rising go, 160 ns bit period
   always @(posedge go)
   begin
      done = 1'b0;
      #7;
      slave_sel_n = 1'b0;
      #160;
      for (int i = 7; i >= 0; i--)
      begin
         sdi = tx_byte[i];
         #80;
         sck_in = 1'b1;
         #79;
         rx_byte[i] = serial_out_pin;
         #1;
         sck_in = 1'b0;
      end
      // Released line shows the inverse of its last bit
      sdi = ~sdi;
      #160;
      slave_sel_n = 1'b1;
      done = 1'b1;
   end
endmodule

// File: dv/sce_spi_ctrl_tb_top.sv
// Purpose: Self-checking bench of the serial control block.
// Assumes: Link model drives the slave pins.
// Notes: Checker bound at the foot.
`timescale 1ns/1ps
module sce_spi_ctrl_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic cpu_idle = 1'b0, go = 1'b0;
   logic [7:0] paddr = 8'h00, tx_byte = 8'h00, rx_byte;
   logic [31:0] pwdata = 32'h0000_0000, prdata, word, first, q;
   logic pready, pslverr, e, sck_in, slave_sel_n, sdi, done;
   logic serial_out_pin, serial_out_oe, sck_oe, left_right_oe, event_out;
   logic sck_out, left_right_clock, sck_old = 1'b0;
   int bad_count = 0;
   int check_count = 0;
   int sck_n = 0;
   int seed = 32'h6F53;
   int ebit[9] = '{5, 3, 7, 11, 0, 1, 6, 8, 12};
   logic [8:0] eexp = 9'h007;
   always #10 pclk = ~pclk;
   sce_spi_ctrl #(.DEPTH(8)) i_dut
   (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_idle(cpu_idle), .sck_in(sck_in), .sck_out(sck_out),
      .sck_oe(sck_oe),
      .sdi(sdi), .serial_out_pin(serial_out_pin),
      .serial_out_oe(serial_out_oe), .slave_sel_n(slave_sel_n),
      .left_right_clock(left_right_clock), .left_right_oe(left_right_oe),
      .event_out(event_out)
   );
   sce_link_model i_link
   (
      .go(go), .tx_byte(tx_byte), .serial_out_pin(serial_out_pin),
      .sck_in(sck_in), .slave_sel_n(slave_sel_n), .sdi(sdi),
      .rx_byte(rx_byte), .done(done)
   );
   function automatic logic [31:0] masked(input logic [7:0] a,
      input logic [31:0] d);
      return {16'h0000, d[15:0] & ((a == 8'h00) ? 16'hBFFF : 16'h19EB)};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 200)
      begin
         n++;
         @(posedge pclk);
      end
      if (n == 200)
      begin
         bad_count++;
         conclude;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(q, exp);
   endtask
   task automatic evt(input logic [31:0] d, input logic exp);
      apb(1'b1, 8'h04, d);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check({31'h0, event_out}, {31'h0, exp});
      @(posedge pclk);
   endtask
   task automatic frame(input logic busy_exp);
      int n;
      n = 0;
      @(posedge pclk);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      while (sck_in !== 1'b1 && n < 400)
      begin
         n++;
         @(posedge pclk);
      end
      @(negedge pclk);
      check({31'h0, event_out}, {31'h0, busy_exp});
      while (done !== 1'b1 && n < 800)
      begin
         n++;
         @(posedge pclk);
      end
      if (n >= 400)
      begin
         bad_count++;
         conclude;
      end
      // Let the deselect pass the synchroniser before idle is released
      repeat (3) @(posedge pclk);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h00, 32'h0000_0000);
      rd(8'h04, 32'h0000_0000);
      for (int i = 0; i < 6; i++)
      begin
         word = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
         apb(1'b1, 8'h00, word);
         rd(8'h00, masked(8'h00, word));
         check({31'h0, serial_out_oe}, {31'h0, word[15] & ~word[12]});
         word = $random(seed);
         apb(1'b1, 8'h04, word);
         rd(8'h04, masked(8'h04, word));
      end
      apb(1'b0, 8'h40, 32'h0000_0000);
      check(q, 32'h0000_0000);
      check({31'h0, e}, 32'h0000_0001);
      apb(1'b1, 8'h00, 32'h0000_0000);
      evt(32'h0000_19EB, 1'b0);
      apb(1'b1, 8'h00, 32'h0000_8000);
      for (int i = 0; i < 9; i++)
         evt(32'h1 << ebit[i], eexp[i]);
      for (int i = 0; i < 8; i++)
      begin
         word = $random(seed);
         if (i == 0)
            first = word;
         apb(1'b1, 8'h10, word);
      end
      evt(32'h0000_0002, 1'b1);
      evt(32'h0000_0008, 1'b0);
      evt(32'h0000_0800, 1'b0);
      word = $random(seed);
      tx_byte <= word[7:0];
      cpu_idle <= 1'b1;
      frame(1'b1);
      cpu_idle <= 1'b0;
      rd(8'h14, {24'h0, tx_byte});
      check({24'h0, rx_byte}, {24'h0, first[7:0]});
      apb(1'b1, 8'h00, 32'h0000_A000);
      cpu_idle <= 1'b1;
      frame(1'b0);
      cpu_idle <= 1'b0;
      rd(8'h14, 32'h0000_0000);
      apb(1'b1, 8'h00, 32'h0000_0000);
      apb(1'b1, 8'h00, 32'h0000_8000);
      evt(32'h0000_0008, 1'b1);
      // Audio master word: 16 clocks, channel flips, idle data line
      apb(1'b1, 8'h08, 32'h0000_0001);
      apb(1'b1, 8'h00, 32'h0000_8020);
      word = $random(seed);
      apb(1'b1, 8'h10, word);
      repeat (48)
      begin
         @(negedge pclk);
         if (sck_out && !sck_old)
            sck_n++;
         sck_old = sck_out;
      end
      check(sck_n, 32'h0000_0010);
      check({31'h0, left_right_clock}, 32'h0000_0001);
      rd(8'h14, {16'h0000, {16{~tx_byte[0]}}});
      conclude;
   end
   initial
   begin
      #1000000;
      bad_count++;
      conclude;
   end
endmodule
bind sce_spi_ctrl sce_spi_ctrl_monitor i_mon
(
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sck_out(sck_out), .sck_oe(sck_oe), .serial_out_oe(serial_out_oe),
   .left_right_oe(left_right_oe),
   .event_out(event_out)
);
